// File: verilog/dtc_pkg.sv
// Shared constants, register layouts and counting arithmetic for the dual timer block.
package dtc_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
	localparam logic [7:0] ADDR_COUNT_LOW_ZERO = 8'h8a;
	localparam logic [7:0] ADDR_COUNT_LOW_ONE = 8'h8b;
	localparam logic [7:0] ADDR_COUNT_HIGH_ZERO = 8'h8c;
	localparam logic [7:0] ADDR_COUNT_HIGH_ONE = 8'h8d;
	localparam logic [7:0] ADDR_TIMER_CLOCK_SELECT = 8'h8e;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [1:0] RESERVED_READ = 2'h0;

	// ------------------------------------------------------------------
	// Mode and prescale encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_COUNT13 = 2'h0;
	localparam logic [1:0] MODE_COUNT16 = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
	localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
	localparam logic [1:0] PRESCALE_EXT8 = 2'h3;

	localparam int unsigned DIV_SYS_12 = 12;
	localparam int unsigned DIV_SYS_4 = 4;
	localparam int unsigned DIV_SYS_48 = 48;
	localparam int unsigned DIV_EXT_8 = 8;

	// ------------------------------------------------------------------
	// Register layouts
	// ------------------------------------------------------------------
	typedef struct packed {
		logic overflow_flag_one;
		logic run_ctl_one;
		logic overflow_flag_zero;
		logic run_ctl_zero;
		logic ext_irq_flag_one;
		logic ext_irq_type_one;
		logic ext_irq_flag_zero;
		logic ext_irq_type_zero;
	} dtc_control_type;

	typedef struct packed {
		logic gate_ctl_one;
		logic count_select_one;
		logic [1:0] mode_sel_one;
		logic gate_ctl_zero;
		logic count_select_zero;
		logic [1:0] mode_sel_zero;
	} dtc_mode_type;

	typedef struct packed {
		logic [1:0] reserved;
		logic third_timer_high_clk_sel;
		logic third_timer_low_clk_sel;
		logic clk_sel_one;
		logic clk_sel_zero;
		logic [1:0] prescale_sel;
	} dtc_clock_select_type;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic overflow;
	} dtc_count_type;

	// ------------------------------------------------------------------
	// One counting step of a timer in modes 0, 1 and 2
	// ------------------------------------------------------------------
	function automatic dtc_count_type dtc_step(input logic [1:0] mode, input logic [7:0] high,
		input logic [7:0] low, input logic tick);
		dtc_count_type res;
		logic [5:0] low5;
		logic [8:0] low9;
		logic [8:0] high9;
		res.high = high;
		res.low = low;
		res.overflow = 1'b0;
		low5 = {1'b0, low[4:0]} + 6'h01;
		low9 = {1'b0, low} + 9'h001;
		high9 = {1'b0, high} + 9'h001;
		if (tick) begin
			case (mode)
				MODE_COUNT13: begin
					// Upper three bits of the low byte are left untouched.
					res.low = {low[7:5], low5[4:0]};
					if (low5[5]) begin
						res.high = high9[7:0];
						res.overflow = high9[8];
					end
				end
				MODE_COUNT16: begin
					res.low = low9[7:0];
					if (low9[8]) begin
						res.high = high9[7:0];
						res.overflow = high9[8];
					end
				end
				MODE_RELOAD8: begin
					res.low = low9[8] ? high : low9[7:0];
					res.overflow = low9[8];
				end
				default: begin
					res.overflow = 1'b0;
				end
			endcase
		end
		return res;
	endfunction : dtc_step

endpackage : dtc_pkg

// File: verilog/dtc_sync_edge.sv
// Two-stage synchroniser with edge detection for asynchronous pins.
`timescale 1ns/10ps
module dtc_sync_edge #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise,
	output logic [WIDTH-1:0] o_fall
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] last_ff;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
			last_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign o_level = sync_ff;
	assign o_rise = sync_ff & ~last_ff;
	assign o_fall = last_ff & ~sync_ff;

endmodule : dtc_sync_edge

// File: verilog/dtc_prescaler.sv
// Shared prescaler producing divided system clock and external clock ticks.
`timescale 1ns/10ps
module dtc_prescaler
	import dtc_pkg::*;
#(
	parameter int unsigned CNT_W = 6
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_prescale_sel,
	input wire logic i_ext_rise,
	output logic o_presc_tick,
	output logic o_div12_tick,
	output logic o_ext8_tick
);

	logic [CNT_W-1:0] cnt12_ff;
	logic [CNT_W-1:0] cnt4_ff;
	logic [CNT_W-1:0] cnt48_ff;
	logic [CNT_W-1:0] cnt_ext_ff;
	logic div4_tick;
	logic div48_tick;

	function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] cnt,
		input int unsigned div);
		if (cnt == CNT_W'(div - 1)) begin
			return '0;
		end
		return cnt + CNT_W'(1);
	endfunction : wrap_inc

	assign o_div12_tick = (cnt12_ff == CNT_W'(DIV_SYS_12 - 1));
	assign div4_tick = (cnt4_ff == CNT_W'(DIV_SYS_4 - 1));
	assign div48_tick = (cnt48_ff == CNT_W'(DIV_SYS_48 - 1));
	// The external clock edges are already synchronised, so this tick is system-clock aligned.
	assign o_ext8_tick = i_ext_rise && (cnt_ext_ff == CNT_W'(DIV_EXT_8 - 1));

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt12_ff <= '0;
			cnt4_ff <= '0;
			cnt48_ff <= '0;
		end else begin
			cnt12_ff <= wrap_inc(cnt12_ff, DIV_SYS_12);
			cnt4_ff <= wrap_inc(cnt4_ff, DIV_SYS_4);
			cnt48_ff <= wrap_inc(cnt48_ff, DIV_SYS_48);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ext_ff <= '0;
		end else if (i_ext_rise) begin
			cnt_ext_ff <= wrap_inc(cnt_ext_ff, DIV_EXT_8);
		end
	end

	always_comb begin
		case (i_prescale_sel)
			PRESCALE_DIV12: o_presc_tick = o_div12_tick;
			PRESCALE_DIV4: o_presc_tick = div4_tick;
			PRESCALE_DIV48: o_presc_tick = div48_tick;
			PRESCALE_EXT8: o_presc_tick = o_ext8_tick;
			default: o_presc_tick = 1'b0;
		endcase
	end

endmodule : dtc_prescaler

// File: verilog/dtc_timer_top.sv
// Control, mode, clock-select and count registers for two counter/timers.
`timescale 1ns/10ps

module dtc_timer_top
	import dtc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	input wire logic i_event_pin_zero,
	input wire logic i_event_pin_one,
	input wire logic i_ext_irq_in_zero,
	input wire logic i_ext_irq_in_one,
	input wire logic i_ext_clk,
	input wire logic i_ext_irq_pol_zero,
	input wire logic i_ext_irq_pol_one,
	input wire logic i_vector_timer_zero,
	input wire logic i_vector_timer_one,
	input wire logic i_vector_ext_zero,
	input wire logic i_vector_ext_one,
	input wire logic i_third_timer_split,
	input wire logic i_third_timer_ext_clk_sel,
	output logic o_overflow_flag_zero,
	output logic o_overflow_flag_one,
	output logic o_ext_irq_flag_zero,
	output logic o_ext_irq_flag_one,
	output logic o_timer_one_overflow,
	output logic o_third_high_tick,
	output logic o_third_low_tick
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	dtc_control_type ctl_ff;
	dtc_mode_type mode_ff;
	dtc_clock_select_type cksel_ff;
	logic [7:0] low_zero_ff;
	logic [7:0] high_zero_ff;
	logic [7:0] low_one_ff;
	logic [7:0] high_one_ff;
	logic [7:0] rdata_ff;
	logic t1_ovf_pulse_ff;
	logic third_high_tick_ff;
	logic third_low_tick_ff;

	// ------------------------------------------------------------------
	// Pin synchronisation and prescaler
	// ------------------------------------------------------------------
	// Bit order: external clock, irq one, irq zero, event one, event zero.
	logic [4:0] pin_level;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;
	logic presc_tick;
	logic div12_tick;
	logic ext8_tick;

	dtc_sync_edge #(
		.WIDTH(5)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async({i_ext_clk, i_ext_irq_in_one, i_ext_irq_in_zero, i_event_pin_one,
			i_event_pin_zero}),
		.o_level(pin_level),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	dtc_prescaler u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_prescale_sel(cksel_ff.prescale_sel),
		.i_ext_rise(pin_rise[4]),
		.o_presc_tick(presc_tick),
		.o_div12_tick(div12_tick),
		.o_ext8_tick(ext8_tick)
	);

	// ------------------------------------------------------------------
	// Interrupt input qualification
	// ------------------------------------------------------------------
	logic irq_active_zero;
	logic irq_active_one;
	logic irq_edge_zero;
	logic irq_edge_one;

	// Polarity one means active high.
	assign irq_active_zero = (pin_level[2] == i_ext_irq_pol_zero);
	assign irq_active_one = (pin_level[3] == i_ext_irq_pol_one);
	assign irq_edge_zero = i_ext_irq_pol_zero ? pin_rise[2] : pin_fall[2];
	assign irq_edge_one = i_ext_irq_pol_one ? pin_rise[3] : pin_fall[3];

	// ------------------------------------------------------------------
	// Run, gate and clock source selection
	// ------------------------------------------------------------------
	logic split_zero;
	logic run_zero;
	logic run_one;
	logic src_zero;
	logic src_one;
	logic tick_zero;
	logic tick_one;
	logic tick_high_split;

	assign split_zero = (mode_ff.mode_sel_zero == MODE_SPLIT);

	assign run_zero = ctl_ff.run_ctl_zero &&
		(!mode_ff.gate_ctl_zero || irq_active_zero);

	// While timer zero is split, timer one ignores its run bit; only its gate and its mode stop it.
	assign run_one = (split_zero || ctl_ff.run_ctl_one) &&
		(!mode_ff.gate_ctl_one || irq_active_one) &&
		(mode_ff.mode_sel_one != MODE_SPLIT);

	assign src_zero = mode_ff.count_select_zero ? pin_fall[0] :
		(cksel_ff.clk_sel_zero ? 1'b1 : presc_tick);

	// Timer one cannot take external events while timer zero is split.
	assign src_one = (mode_ff.count_select_one && !split_zero) ? pin_fall[1] :
		(cksel_ff.clk_sel_one ? 1'b1 : presc_tick);

	assign tick_zero = run_zero && src_zero;
	assign tick_one = run_one && src_one;

	// The split high byte is a pure timer gated by timer one's run bit.
	assign tick_high_split = ctl_ff.run_ctl_one &&
		(cksel_ff.clk_sel_zero ? 1'b1 : presc_tick);

	// ------------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------------
	dtc_count_type step_zero;
	dtc_count_type step_one;
	logic [8:0] split_low;
	logic [8:0] split_high;
	dtc_count_type nxt_zero;
	logic ovf_zero;
	logic ovf_one_flag;

	assign step_zero = dtc_step(mode_ff.mode_sel_zero, high_zero_ff, low_zero_ff, tick_zero);
	assign step_one = dtc_step(mode_ff.mode_sel_one, high_one_ff, low_one_ff, tick_one);
	assign split_low = {1'b0, low_zero_ff} + 9'h001;
	assign split_high = {1'b0, high_zero_ff} + 9'h001;

	always_comb begin
		nxt_zero = step_zero;
		if (split_zero) begin
			nxt_zero.low = tick_zero ? split_low[7:0] : low_zero_ff;
			nxt_zero.high = tick_high_split ? split_high[7:0] : high_zero_ff;
			nxt_zero.overflow = tick_zero && split_low[8];
		end
	end

	assign ovf_zero = nxt_zero.overflow;
	// Timer one's own overflow cannot reach its flag while timer zero is split.
	assign ovf_one_flag = split_zero ? (tick_high_split && split_high[8]) : step_one.overflow;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic wr_ctl;
	logic wr_mode;
	logic wr_cksel;
	logic wr_low_zero;
	logic wr_high_zero;
	logic wr_low_one;
	logic wr_high_one;

	assign wr_ctl = i_sfr_wr && (i_sfr_addr == ADDR_TIMER_CONTROL);
	assign wr_mode = i_sfr_wr && (i_sfr_addr == ADDR_TIMER_MODE);
	assign wr_cksel = i_sfr_wr && (i_sfr_addr == ADDR_TIMER_CLOCK_SELECT);
	assign wr_low_zero = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_LOW_ZERO);
	assign wr_high_zero = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_HIGH_ZERO);
	assign wr_low_one = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_LOW_ONE);
	assign wr_high_one = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_HIGH_ONE);

	// ------------------------------------------------------------------
	// Control register: software write, vector clears, then hardware sets
	// ------------------------------------------------------------------
	dtc_control_type nxt_ctl;

	always_comb begin
		nxt_ctl = wr_ctl ? dtc_control_type'(i_sfr_wdata) : ctl_ff;
		if (i_vector_timer_one) begin
			nxt_ctl.overflow_flag_one = 1'b0;
		end
		if (ovf_one_flag) begin
			nxt_ctl.overflow_flag_one = 1'b1;
		end
		if (i_vector_timer_zero) begin
			nxt_ctl.overflow_flag_zero = 1'b0;
		end
		if (ovf_zero) begin
			nxt_ctl.overflow_flag_zero = 1'b1;
		end
		if (ctl_ff.ext_irq_type_one) begin
			if (i_vector_ext_one) begin
				nxt_ctl.ext_irq_flag_one = 1'b0;
			end
			if (irq_edge_one) begin
				nxt_ctl.ext_irq_flag_one = 1'b1;
			end
		end else begin
			nxt_ctl.ext_irq_flag_one = irq_active_one;
		end
		if (ctl_ff.ext_irq_type_zero) begin
			if (i_vector_ext_zero) begin
				nxt_ctl.ext_irq_flag_zero = 1'b0;
			end
			if (irq_edge_zero) begin
				nxt_ctl.ext_irq_flag_zero = 1'b1;
			end
		end else begin
			nxt_ctl.ext_irq_flag_zero = irq_active_zero;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_ff <= dtc_control_type'(REG_RESET);
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// ------------------------------------------------------------------
	// Mode and clock-select registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_ff <= dtc_mode_type'(REG_RESET);
		end else if (wr_mode) begin
			mode_ff <= dtc_mode_type'(i_sfr_wdata);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cksel_ff <= dtc_clock_select_type'(REG_RESET);
		end else if (wr_cksel) begin
			cksel_ff <= dtc_clock_select_type'({RESERVED_READ, i_sfr_wdata[5:0]});
		end
	end

	// ------------------------------------------------------------------
	// Count registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			low_zero_ff <= REG_RESET;
			high_zero_ff <= REG_RESET;
		end else begin
			low_zero_ff <= wr_low_zero ? i_sfr_wdata : nxt_zero.low;
			high_zero_ff <= wr_high_zero ? i_sfr_wdata : nxt_zero.high;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			low_one_ff <= REG_RESET;
			high_one_ff <= REG_RESET;
		end else begin
			low_one_ff <= wr_low_one ? i_sfr_wdata : step_one.low;
			high_one_ff <= wr_high_one ? i_sfr_wdata : step_one.high;
		end
	end

	// ------------------------------------------------------------------
	// Third timer clock ticks
	// ------------------------------------------------------------------
	logic third_ext_tick;
	logic third_low_src;
	logic third_high_src;

	assign third_ext_tick = i_third_timer_ext_clk_sel ? ext8_tick : div12_tick;
	assign third_low_src = cksel_ff.third_timer_low_clk_sel ? 1'b1 : third_ext_tick;
	// Outside split mode the high byte follows the low byte clock.
	assign third_high_src = !i_third_timer_split ? third_low_src :
		(cksel_ff.third_timer_high_clk_sel ? 1'b1 : third_ext_tick);

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			third_low_tick_ff <= 1'b0;
			third_high_tick_ff <= 1'b0;
		end else begin
			third_low_tick_ff <= third_low_src;
			third_high_tick_ff <= third_high_src;
		end
	end

	// ------------------------------------------------------------------
	// Timer one overflow pulse for serial baud generation
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			t1_ovf_pulse_ff <= 1'b0;
		end else begin
			t1_ovf_pulse_ff <= step_one.overflow;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [7:0] rd_value;

	always_comb begin
		case (i_sfr_addr)
			ADDR_TIMER_CONTROL: rd_value = ctl_ff;
			ADDR_TIMER_MODE: rd_value = mode_ff;
			ADDR_COUNT_LOW_ZERO: rd_value = low_zero_ff;
			ADDR_COUNT_LOW_ONE: rd_value = low_one_ff;
			ADDR_COUNT_HIGH_ZERO: rd_value = high_zero_ff;
			ADDR_COUNT_HIGH_ONE: rd_value = high_one_ff;
			ADDR_TIMER_CLOCK_SELECT: rd_value = {RESERVED_READ, cksel_ff[5:0]};
			default: rd_value = READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= REG_RESET;
		end else if (i_sfr_rd) begin
			rdata_ff <= rd_value;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_sfr_rdata = rdata_ff;
	assign o_overflow_flag_zero = ctl_ff.overflow_flag_zero;
	assign o_overflow_flag_one = ctl_ff.overflow_flag_one;
	assign o_ext_irq_flag_zero = ctl_ff.ext_irq_flag_zero;
	assign o_ext_irq_flag_one = ctl_ff.ext_irq_flag_one;
	assign o_timer_one_overflow = t1_ovf_pulse_ff;
	assign o_third_high_tick = third_high_tick_ff;
	assign o_third_low_tick = third_low_tick_ff;

endmodule : dtc_timer_top

// File: tb/dtc_timer_properties.sv
// Concurrent checks on the ports of the dual timer block.
`timescale 1ns/10ps
module dtc_timer_properties
	import dtc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic i_ext_irq_in_one,
	input wire logic i_ext_irq_pol_one,
	input wire logic i_vector_timer_zero,
	input wire logic i_vector_timer_one,
	input wire logic i_third_timer_split,
	input wire logic o_overflow_flag_zero,
	input wire logic o_overflow_flag_one,
	input wire logic o_ext_irq_flag_one,
	input wire logic o_timer_one_overflow,
	input wire logic o_third_high_tick,
	input wire logic o_third_low_tick
);
	logic type_one_ff;
	logic low_sys_ff;
	logic [1:0] mode_zero_ff;
	logic wr_ctl;
	logic clr_zero;
	logic clr_one;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	assign wr_ctl = i_sfr_wr && i_sfr_addr == ADDR_TIMER_CONTROL;
	assign clr_zero = wr_ctl && !i_sfr_wdata[5];
	assign clr_one = wr_ctl && !i_sfr_wdata[7];
	// Shadow copies of the configuration bits the properties depend on.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			type_one_ff <= 1'b0;
			low_sys_ff <= 1'b0;
			mode_zero_ff <= 2'h0;
		end else if (i_sfr_wr) begin
			if (i_sfr_addr == ADDR_TIMER_CONTROL) type_one_ff <= i_sfr_wdata[2];
			if (i_sfr_addr == ADDR_TIMER_CLOCK_SELECT) low_sys_ff <= i_sfr_wdata[4];
			if (i_sfr_addr == ADDR_TIMER_MODE) mode_zero_ff <= i_sfr_wdata[1:0];
		end
	end
	sequence s_lvl_act;
		!type_one_ff && i_ext_irq_in_one == i_ext_irq_pol_one;
	endsequence
	property p_lvl_one;
		s_lvl_act [*5] |-> o_ext_irq_flag_one;
	endproperty
	a_lvl_one: assert property (p_lvl_one) else $error("ext flag one not following level");
	property p_fall_zero;
		$fell(o_overflow_flag_zero) |-> $past(i_vector_timer_zero) || $past(clr_zero);
	endproperty
	a_fall_zero: assert property (p_fall_zero) else $error("flag zero cleared unasked");
	property p_fall_one;
		$fell(o_overflow_flag_one) |-> $past(i_vector_timer_one) || $past(clr_one);
	endproperty
	a_fall_one: assert property (p_fall_one) else $error("flag one cleared unasked");
	property p_ovf_flag;
		o_timer_one_overflow && mode_zero_ff != MODE_SPLIT |-> o_overflow_flag_one;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("wrap without flag one");
	property p_rsv;
		i_sfr_rd && i_sfr_addr == ADDR_TIMER_CLOCK_SELECT |=> o_sfr_rdata[7:6] == RESERVED_READ;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_unmap;
		i_sfr_rd && i_sfr_addr == 8'h8f |=> o_sfr_rdata == READ_UNMAPPED;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_stand;
		!i_sfr_rd |=> $stable(o_sfr_rdata);
	endproperty
	a_stand: assert property (p_stand) else $error("read data moved without read");
	property p_low_sys;
		low_sys_ff [*3] |-> o_third_low_tick;
	endproperty
	a_low_sys: assert property (p_low_sys) else $error("low tick not system clock");
	property p_high_eq;
		!i_third_timer_split [*2] |-> o_third_high_tick == o_third_low_tick;
	endproperty
	a_high_eq: assert property (p_high_eq) else $error("high tick differs outside split");
endmodule : dtc_timer_properties

bind dtc_timer_top dtc_timer_properties u_props (.*);

// File: tb/dtc_cpu_model.sv
// Behavioural CPU core driving the register bus and vector acknowledges.
`timescale 1ns/10ps
module dtc_cpu_model
	import dtc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic [7:0] i_sfr_rdata,
	output logic [7:0] o_sfr_addr,
	output logic o_sfr_wr,
	output logic o_sfr_rd,
	output logic [7:0] o_sfr_wdata,
	output logic [3:0] o_vec
);
	initial begin
		o_sfr_addr = 8'h00;
		o_sfr_wr = 1'b0;
		o_sfr_rd = 1'b0;
		o_sfr_wdata = 8'h00;
		o_vec = 4'h0;
	end
	// Released lines show the inverse so stale values are never mistaken for data.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_sfr_addr = a;
		o_sfr_wdata = (a == ADDR_TIMER_CLOCK_SELECT) ? {2'h0, d[5:0]} : d;
		o_sfr_wr = 1'b1;
		@(negedge i_ref_clk);
		o_sfr_wr = 1'b0;
		o_sfr_addr = ~a;
		o_sfr_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		o_sfr_addr = a;
		o_sfr_rd = 1'b1;
		@(negedge i_ref_clk);
		o_sfr_rd = 1'b0;
		o_sfr_addr = ~a;
		d = i_sfr_rdata;
	endtask : rd
	task automatic vec(input logic [3:0] v);
		@(negedge i_ref_clk);
		o_vec = v;
		@(negedge i_ref_clk);
		o_vec = 4'h0;
	endtask : vec
endmodule : dtc_cpu_model

// File: tb/dtc_timer_top_bench.sv
// Self-checking bench for the dual timer register block.
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module dtc_timer_top_bench
	import dtc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic [3:0] vec;
	logic pin0 = 1'b1;
	logic irq_in = 1'b0;
	logic pol = 1'b0;
	logic pin1 = 1'b1;
	logic ext_clk = 1'b0;
	logic split = 1'b0;
	logic t1ovf;
	logic th_tick;
	logic tl_tick;
	logic ovf0;
	logic ovf1;
	logic ext0;
	logic ext1;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	always #50 ref_clk = ~ref_clk;
	dtc_timer_top dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_event_pin_zero(pin0),
		.i_event_pin_one(pin1), .i_ext_irq_in_zero(irq_in), .i_ext_irq_in_one(irq_in),
		.i_ext_clk(ext_clk), .i_ext_irq_pol_zero(pol), .i_ext_irq_pol_one(pol),
		.i_vector_timer_zero(vec[0]), .i_vector_timer_one(vec[1]), .i_vector_ext_zero(vec[2]),
		.i_vector_ext_one(vec[3]), .i_third_timer_split(split), .i_third_timer_ext_clk_sel(1'b0),
		.o_overflow_flag_zero(ovf0), .o_overflow_flag_one(ovf1), .o_ext_irq_flag_zero(ext0),
		.o_ext_irq_flag_one(ext1), .o_timer_one_overflow(t1ovf), .o_third_high_tick(th_tick),
		.o_third_low_tick(tl_tick));
	dtc_cpu_model cpu (.i_ref_clk(ref_clk), .i_sfr_rdata(rdata), .o_sfr_addr(addr),
		.o_sfr_wr(wr), .o_sfr_rd(rd), .o_sfr_wdata(wdata), .o_vec(vec));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpu.rd(a, d);
		`CHK("rdata", e, d)
	endtask : chk_rd
	task automatic pulses(input int n);
		repeat (n) begin
			pin0 = 1'b0;
			pin1 = 1'b0;
			repeat (4) @(negedge ref_clk);
			pin0 = 1'b1;
			pin1 = 1'b1;
			repeat (4) @(negedge ref_clk);
		end
	endtask : pulses
	task automatic t_regs();
		// Low inputs with active-low polarity hold both level-mode flags set.
		chk_rd(ADDR_TIMER_CONTROL, 8'h0a);
		for (int a = 8'h89; a < 8'h90; a++) chk_rd(8'(a), 8'h00);
		for (int a = 8'h8a; a < 8'h8e; a++) begin
			cpu.wr(8'(a), 8'(a) ^ 8'h5a);
			chk_rd(8'(a), 8'(a) ^ 8'h5a);
		end
		cpu.wr(ADDR_TIMER_CLOCK_SELECT, 8'h3f);
		chk_rd(ADDR_TIMER_CLOCK_SELECT, 8'h3f);
		cpu.wr(8'h8f, 8'hff);
		chk_rd(8'h8f, 8'h00);
	endtask : t_regs
	task automatic t_wrap16();
		cpu.wr(ADDR_TIMER_MODE, 8'h01);
		cpu.wr(ADDR_TIMER_CLOCK_SELECT, 8'h04);
		cpu.wr(ADDR_COUNT_LOW_ZERO, 8'hff);
		cpu.wr(ADDR_COUNT_HIGH_ZERO, 8'hff);
		cpu.wr(ADDR_TIMER_CONTROL, 8'h10);
		@(negedge ref_clk);
		`CHK("ovf0", 1'b1, ovf0)
		chk_rd(ADDR_COUNT_HIGH_ZERO, 8'h00);
		cpu.vec(4'h1);
		`CHK("ovf0", 1'b0, ovf0)
		cpu.wr(ADDR_COUNT_LOW_ZERO, 8'h40);
		chk_rd(ADDR_COUNT_LOW_ZERO, 8'h41);
		cpu.wr(ADDR_TIMER_CONTROL, 8'h00);
	endtask : t_wrap16
	task automatic t_one(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] elo, input logic [7:0] ehi);
		cpu.wr(ADDR_TIMER_MODE, m);
		cpu.wr(ADDR_TIMER_CLOCK_SELECT, 8'h08);
		cpu.wr(ADDR_COUNT_HIGH_ONE, hi);
		cpu.wr(ADDR_COUNT_LOW_ONE, lo);
		cpu.wr(ADDR_TIMER_CONTROL, 8'h40);
		cpu.wr(ADDR_TIMER_CONTROL, 8'h00);
		`CHK("ovf1", 1'b1, ovf1)
		`CHK("t1ovf", 1'b1, t1ovf)
		chk_rd(ADDR_COUNT_LOW_ONE, elo);
		chk_rd(ADDR_COUNT_HIGH_ONE, ehi);
	endtask : t_one
	task automatic t_presc();
		int exp_cnt[4] = '{4, 12, 1, 1};
		for (int p = 0; p < 4; p++) begin
			cpu.wr(ADDR_COUNT_LOW_ONE, 8'h00);
			cpu.wr(ADDR_TIMER_MODE, 8'h10);
			cpu.wr(ADDR_TIMER_CLOCK_SELECT, 8'(p));
			cpu.wr(ADDR_TIMER_CONTROL, 8'h40);
			// The external clock gives twelve rises, of which the eighth ticks.
			repeat (23) begin
				ext_clk = (p == 3) ? ~ext_clk : 1'b0;
				repeat (2) @(negedge ref_clk);
			end
			cpu.wr(ADDR_TIMER_CONTROL, 8'h00);
			chk_rd(ADDR_COUNT_LOW_ONE, 8'(exp_cnt[p]));
		end
	endtask : t_presc
	task automatic t_gate();
		pol = 1'b1;
		cpu.wr(ADDR_COUNT_LOW_ZERO, 8'h00);
		cpu.wr(ADDR_COUNT_LOW_ONE, 8'h00);
		cpu.wr(ADDR_TIMER_MODE, 8'h4d);
		cpu.wr(ADDR_TIMER_CONTROL, 8'h50);
		pulses(3);
		chk_rd(ADDR_COUNT_LOW_ZERO, 8'h00);
		chk_rd(ADDR_COUNT_LOW_ONE, 8'h03);
		irq_in = 1'b1;
		repeat (4) @(negedge ref_clk);
		pulses(3);
		chk_rd(ADDR_COUNT_LOW_ZERO, 8'h03);
		chk_rd(ADDR_COUNT_LOW_ONE, 8'h06);
		`CHK("ext1", 1'b1, ext1)
		cpu.vec(4'hc);
		`CHK("ext0", 1'b1, ext0)
		irq_in = 1'b0;
		repeat (5) @(negedge ref_clk);
		`CHK("ext0", 1'b0, ext0)
		cpu.wr(ADDR_TIMER_CONTROL, 8'h05);
		irq_in = 1'b1;
		repeat (5) @(negedge ref_clk);
		`CHK("ext0", 1'b1, ext0)
		cpu.vec(4'h4);
		`CHK("ext0", 1'b0, ext0)
	endtask : t_gate
	task automatic t_third();
		int n = 0;
		cpu.wr(ADDR_TIMER_CLOCK_SELECT, 8'h10);
		repeat (2) @(negedge ref_clk);
		`CHK("tl_tick", 1'b1, tl_tick)
		`CHK("th_tick", 1'b1, th_tick)
		split = 1'b1;
		repeat (2) @(negedge ref_clk);
		repeat (DIV_SYS_12) begin
			@(negedge ref_clk);
			if (th_tick === 1'b1) n++;
		end
		`CHK("th_ticks", 1, n)
		`CHK("tl_tick", 1'b1, tl_tick)
		split = 1'b0;
	endtask : t_third
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		t_regs();
		t_wrap16();
		t_one(8'h20, 8'hfe, 8'hf0, 8'hf0, 8'hf0);
		t_one(8'h00, 8'hfe, 8'hff, 8'he0, 8'h00);
		t_presc();
		t_gate();
		t_third();
		end_sim();
	end
endmodule : dtc_timer_top_bench
